// ### rtl/rwl_pkg.sv
package rwl_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int           ADDR_W          = 12;
  localparam logic [11:0]  ADDR_PROT_CTRL  = 12'h000;
  localparam logic [11:0]  ADDR_GROUP_BASE = 12'h010;
  localparam int           GROUPS          = 4;
  localparam int           GROUP_W         = 32;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int           KEY_LSB         = 8;
  localparam int           KEY_W           = 8;
  localparam logic [7:0]   UNLOCK_KEY      = 8'hA5;
  localparam logic [3:0]   ENABLE_RESET    = 4'h0;
  localparam logic [31:0]  GROUP_RESET     = 32'h0000_0000;
  localparam int           GRP_CLOCKGEN    = 0;
  localparam int           GRP_MODE_POWER  = 1;
  localparam int           GRP_FAST_OSC    = 2;
  localparam int           GRP_VOLT_DETECT = 3;

  localparam logic [1:0]   HTRANS_NONSEQ   = 2'b10;
  localparam logic [31:0]  READ_ZERO       = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              pend;
    logic              wr;
    logic [ADDR_W-1:0] addr;
  } rwl_aphase_s;

  typedef struct packed {
    rwl_aphase_s       ap;
    logic [3:0]        enable;
    logic [GROUPS-1:0][GROUP_W-1:0] group;
    logic [31:0]       rdata;
  } rwl_state_s;

endpackage : rwl_pkg

// ### rtl/rwl_register_write_lock.sv
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module rwl_register_write_lock
  import rwl_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic      [3:0]              groupWriteEnable,
  output logic      [GROUPS*GROUP_W-1:0] groupRegs
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rwl_state_s stateQ;
  rwl_state_s stateD;
  logic       keyOk;
  int         gIdx;

  assign keyOk = (hwdata[KEY_LSB +: KEY_W] == UNLOCK_KEY);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    stateD = stateQ;
    gIdx   = 0;
    // Address phase capture; zero-wait slave
    stateD.ap.pend = hsel && hready && (htrans == HTRANS_NONSEQ);
    stateD.ap.wr   = hwrite;
    stateD.ap.addr = haddr[ADDR_W-1:0];
    if (stateQ.ap.pend && stateQ.ap.wr) begin
      if (stateQ.ap.addr == ADDR_PROT_CTRL) begin
        if (keyOk) begin
          stateD.enable = hwdata[3:0];
        end
      end else begin
        for (int i = 0; i < GROUPS; i++) begin
          if (stateQ.ap.addr == ADDR_GROUP_BASE + ADDR_W'(4 * i)) begin
            // Blocked writes vanish; response stays OKAY
            if (stateQ.enable[i]) begin
              stateD.group[i] = hwdata;
            end
          end
        end
      end
    end
    // Read data for the following data phase
    stateD.rdata = READ_ZERO;
    if (stateD.ap.pend && !hwrite) begin
      if (haddr[ADDR_W-1:0] == ADDR_PROT_CTRL) begin
        stateD.rdata[3:0] = stateD.enable;
      end else begin
        for (int i = 0; i < GROUPS; i++) begin
          if (haddr[ADDR_W-1:0] == ADDR_GROUP_BASE + ADDR_W'(4 * i)) begin
            gIdx = i;
            stateD.rdata = stateD.group[gIdx];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stateQ.ap     <= '0;
      stateQ.enable <= ENABLE_RESET;
      for (int i = 0; i < GROUPS; i++) begin
        stateQ.group[i] <= GROUP_RESET;
      end
      stateQ.rdata  <= READ_ZERO;
    end else begin
      stateQ <= stateD;
    end
  end

  // Group 0 clock gen, 1 mode/power, 2 fast osc wait, 3 voltage detect
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  assign hrdata           = stateQ.rdata;
  assign hresp            = 1'b0;
  assign groupWriteEnable = stateQ.enable;
  assign groupRegs        = stateQ.group;

endmodule : rwl_register_write_lock

// ### testbench/rwl_checker.sv
`timescale 1ns/1ps
module rwl_checker
  import rwl_pkg::*;
(
  input wire logic          mclk,
  input wire logic          rst_b,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic [31:0]   hwdata,
  input wire logic          hready,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic [3:0]    groupWriteEnable,
  input wire logic [127:0]  groupRegs
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic ctlWr_q;
  // Data phase of a write to the control register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) ctlWr_q <= 1'b0;
    else ctlWr_q <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite
                    && haddr[11:0] == ADDR_PROT_CTRL;
  end
  a_okay_resp: assert property (hresp == 1'b0)
    else $error("resp");
  a_zero_wait: assert property ($past(rst_b) |-> hreadyout)
    else $error("wait state");
  a_key_update: assert property (ctlWr_q
    && hwdata[15:8] == UNLOCK_KEY
    |=> groupWriteEnable == $past(hwdata[3:0])) else $error("no update");
  a_bad_key: assert property (ctlWr_q
    && hwdata[15:8] != UNLOCK_KEY
    |=> $stable(groupWriteEnable)) else $error("bad key took");
  a_enable_cause: assert property ($changed(groupWriteEnable)
    |-> $past(ctlWr_q)) else $error("stray enable change");
  a_reset_clear: assert property (!$past(rst_b)
    |-> groupWriteEnable == ENABLE_RESET) else $error("enable reset");
  a_groups_reset: assert property (!$past(rst_b)
    |-> groupRegs == '0) else $error("group reset");
  a_locked_hold: assert property ($past(groupWriteEnable) == 4'h0
    |-> $stable(groupRegs)) else $error("locked group changed");
endmodule : rwl_checker

bind rwl_register_write_lock rwl_checker chk (.mclk, .rst_b, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .groupWriteEnable,
  .groupRegs);

// ### testbench/rwl_register_write_lock_tb.sv
`timescale 1ns/1ps
module rwl_register_write_lock_tb import rwl_pkg::*; ;
  logic mclk = 0, rst_b = 0, hsel = 1, hwrite = 0, hready, hreadyout, hresp;
  logic [1:0]   htrans = 2'b00;
  logic [2:0]   hsize = 3'b010;
  logic [31:0]  haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
  logic [3:0]   en;
  logic [127:0] grp;
  int mismatches = 0, checked = 0;
  assign hready = hreadyout;
  rwl_register_write_lock dut (.mclk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .groupWriteEnable(en), .groupRegs(grp));
  initial forever #4 mclk = ~mclk;
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    htrans <= HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
    #1;
  endtask : xfer
  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic t_locked;
    chk(en, ENABLE_RESET);
    xfer(1, ADDR_PROT_CTRL, 32'h0000_5A0F);
    chk(en, ENABLE_RESET);
    for (int i = 0; i < GROUPS; i++) begin
      xfer(1, ADDR_GROUP_BASE + 12'(4 * i), 32'hDEAD_BEEF);
      chk(grp[32*i +: 32], GROUP_RESET);
    end
  endtask : t_locked
  task automatic t_groups;
    logic [31:0] ex [GROUPS] = '{default: GROUP_RESET};
    for (int i = 0; i < GROUPS; i++) begin
      xfer(1, ADDR_PROT_CTRL, 32'h0000_A5F0 | (32'h1 << i));
      xfer(0, ADDR_PROT_CTRL, 32'h0000_0000);
      chk(r, 32'h1 << i);
      for (int j = 0; j < GROUPS; j++) begin
        xfer(1, ADDR_GROUP_BASE + 12'(4 * j), 32'h0000_1000 * (i + 1) + j);
        if (j == i) ex[j] = 32'h0000_1000 * (i + 1) + j;
      end
      // Each group in turn: 0 clock gen, 1 mode/power, 2 osc wait, 3 voltage
      for (int j = 0; j < GROUPS; j++) begin
        chk(grp[32*j +: 32], ex[j]);
        xfer(0, ADDR_GROUP_BASE + 12'(4 * j), 32'h0000_0000);
        chk(r, ex[j]);
      end
    end
    xfer(1, ADDR_PROT_CTRL, 32'h0000_A50F);
    chk(en, 4'hF);
    xfer(1, ADDR_PROT_CTRL, 32'h0000_A500);
    chk(en, 4'h0);
    xfer(0, 12'h0FC, 32'h0000_0000);
    chk(r, READ_ZERO);
  endtask : t_groups
  initial begin
    #20000;
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    t_locked;
    t_groups;
    print_verdict;
  end
endmodule : rwl_register_write_lock_tb
